// ===== rtl/rvdm_params.svh
// Constants for the regulator select-pin mapping and discharge registers.
`ifndef RVDM_PARAMS_SVH
`define RVDM_PARAMS_SVH

// Printed register offsets, kept as word indices.
`define RVDM_IDX_PIN_MAP       8'h2C
`define RVDM_IDX_DRAIN_A       8'h2D
`define RVDM_IDX_DRAIN_B       8'h2E
// Word index of the read-only status word.
`define RVDM_IDX_STATUS        8'h40

// Bus address width and the word-address slice.
`define RVDM_ADDR_W            12
`define RVDM_WORD_LSB          2

// Map field layout: regulator n sits at bits 2n+1:2n.
`define RVDM_MAP_FIELD_W       2
`define RVDM_MAP_REGS          4

// Writable mask of the second drain register.
`define RVDM_DRAIN_B_MASK      8'h3F
// Field positions inside the second drain register.
`define RVDM_DRAIN_B_LIN_LSB   0
`define RVDM_DRAIN_B_CNV_LSB   2

// Counts of regulators and converters.
`define RVDM_LINREGS           10
`define RVDM_CONVERTERS        4
`define RVDM_SEL_PINS          4

// Response codes of the register bus.
`define RVDM_RESP_OKAY         2'h0
`define RVDM_RESP_SLVERR       2'h2

// Reset values of the default-voltage bits before the pins are seen.
`define RVDM_DEF_BITS_RESET    4'h0

`endif

// ===== rtl/rvdm_pin_sync.sv
// Two-stage synchroniser for the voltage select pins.
`timescale 1ns/1ps
`include "rvdm_params.svh"

module rvdm_pin_sync (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [`RVDM_SEL_PINS-1:0]  pin_raw,
  output logic      [`RVDM_SEL_PINS-1:0]  pin_sync
);

  // First stage; only the second stage reads it.
  logic [`RVDM_SEL_PINS-1:0] stage_one_reg;

  // Both stages clear on reset so the outputs start at a known level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_one_reg <= '0;
      pin_sync      <= '0;
    end else begin
      stage_one_reg <= pin_raw;
      pin_sync      <= stage_one_reg;
    end
  end

endmodule : rvdm_pin_sync

// ===== rtl/rvdm_pkg.sv
// Types shared by the regulator select-pin mapping and discharge block.
package rvdm_pkg;

  // One eight-bit configuration register.
  typedef logic [7:0] rvdm_byte_t;

  // Selected-voltage codes for linear regulators 1 to 4.
  typedef logic [3:0][7:0] rvdm_code_bank_t;

  // Map field codes and the select pin that each chooses.
  typedef enum logic [1:0] {
    RVDM_PIN_ONE   = 2'b00,
    RVDM_PIN_TWO   = 2'b01,
    RVDM_PIN_THREE = 2'b10,
    RVDM_PIN_FOUR  = 2'b11
  } rvdm_pin_sel_e;

  // Registers that a bus address can reach.
  typedef enum logic [2:0] {
    RVDM_REG_NONE   = 3'b000,
    RVDM_REG_MAP    = 3'b001,
    RVDM_REG_DRAIN_A = 3'b010,
    RVDM_REG_DRAIN_B = 3'b011,
    RVDM_REG_STATUS = 3'b100
  } rvdm_reg_e;

endpackage : rvdm_pkg

// ===== rtl/rvdm_regs.sv
// Select-pin mapping, default-voltage and output drain register block.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "rvdm_params.svh"

module rvdm_regs (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Register bus write address channel.
  input  wire logic [`RVDM_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // Register bus write data channel.
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // Register bus write response channel.
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // Register bus read address channel.
  input  wire logic [`RVDM_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // Register bus read data channel.
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Factory values loaded at power-on reset.
  input  wire rvdm_pkg::rvdm_byte_t          otp_pin_map,
  input  wire rvdm_pkg::rvdm_byte_t          otp_drain_a,
  input  wire rvdm_pkg::rvdm_byte_t          otp_drain_b,
  // Voltage select pins from the host.
  input  wire logic [`RVDM_SEL_PINS-1:0]     voltage_select_pin,
  // Voltage codes of linear regulators 1 to 4.
  input  wire rvdm_pkg::rvdm_code_bank_t     linreg_primary_voltage_reg,
  input  wire rvdm_pkg::rvdm_code_bank_t     linreg_alternate_voltage_reg,
  // Enable state of each output.
  input  wire logic [`RVDM_LINREGS-1:0]      linreg_enabled,
  input  wire logic [`RVDM_CONVERTERS-1:0]   converter_enabled,
  // Default-voltage bits and resulting voltage codes.
  output logic [`RVDM_MAP_REGS-1:0]          default_voltage_source_bit,
  output rvdm_pkg::rvdm_code_bank_t          linreg_voltage_code,
  // Drain switch commands.
  output logic [`RVDM_LINREGS-1:0]           linreg_drain_on,
  output logic [`RVDM_CONVERTERS-1:0]        converter_drain_on
);

  import rvdm_pkg::*;

  // Configuration registers.
  rvdm_byte_t                   pin_map_reg;   // Select-pin mapping.
  rvdm_byte_t                   drain_a_reg;   // Linear regulators 1-8.
  rvdm_byte_t                   drain_b_reg;   // Converters and linregs 9-10.

  // Synchronised select pins.
  logic [`RVDM_SEL_PINS-1:0]    sel_pin_sync;

  // Write channel holding state.
  logic                         aw_full_reg;   // Address taken, not used.
  logic                         w_full_reg;    // Data taken, not used.
  logic [`RVDM_ADDR_W-1:0]      aw_addr_reg;   // Held write address.
  logic [31:0]                  w_data_reg;    // Held write data.
  logic                         w_lane0_reg;   // Byte lane 0 strobe.

  // Handshake terms.
  logic                         aw_take;
  logic                         w_take;
  logic                         ar_take;
  logic                         wr_fire;
  logic                         aw_full_next;
  logic                         w_full_next;
  logic                         bvalid_next;
  logic                         rvalid_next;
  rvdm_reg_e                    wr_target;
  rvdm_reg_e                    rd_target;

  // Maps a bus byte address onto the register it reaches.
  function automatic rvdm_reg_e decode_addr(
    input logic [`RVDM_ADDR_W-1:0] addr
  );
    logic [`RVDM_ADDR_W-3:0] word;
    word = addr[`RVDM_ADDR_W-1:`RVDM_WORD_LSB];
    case (word)
      10'(`RVDM_IDX_PIN_MAP): decode_addr = RVDM_REG_MAP;
      10'(`RVDM_IDX_DRAIN_A): decode_addr = RVDM_REG_DRAIN_A;
      10'(`RVDM_IDX_DRAIN_B): decode_addr = RVDM_REG_DRAIN_B;
      10'(`RVDM_IDX_STATUS):  decode_addr = RVDM_REG_STATUS;
      default:                decode_addr = RVDM_REG_NONE;
    endcase
  endfunction : decode_addr

  // Picks the select pin that a two-bit map field names.
  function automatic logic pick_pin(
    input logic [1:0]                map_field,
    input logic [`RVDM_SEL_PINS-1:0] pins
  );
    case (rvdm_pin_sel_e'(map_field))
      RVDM_PIN_ONE:   pick_pin = pins[0];
      RVDM_PIN_TWO:   pick_pin = pins[1];
      RVDM_PIN_THREE: pick_pin = pins[2];
      RVDM_PIN_FOUR:  pick_pin = pins[3];
      default:        pick_pin = pins[0];
    endcase
  endfunction : pick_pin

  // Raw pins are asynchronous to the bus clock; a glitch must never
  // reach the voltage selection directly.
  rvdm_pin_sync u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_raw  (voltage_select_pin),
    .pin_sync (sel_pin_sync)
  );

  // Handshakes happen when the slave's ready flop and valid meet.
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // A write commits once both halves are held and no answer is pending.
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;

  // Held halves free up only when the write commits.
  assign aw_full_next = (aw_full_reg | aw_take) & ~wr_fire;
  assign w_full_next  = (w_full_reg | w_take) & ~wr_fire;

  // Write answer stands until the master takes it.
  assign bvalid_next = wr_fire | (s_axi_bvalid & ~s_axi_bready);

  // Read answer stands until the master takes it.
  assign rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // Targets of the held write and the incoming read.
  assign wr_target = decode_addr(aw_addr_reg);
  assign rd_target = decode_addr(s_axi_araddr);

  // Write address half: held until the write commits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      // Stay closed while a write is held or its answer is pending.
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
    end
  end

  // Write data half: held until the write commits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg   <= 1'b0;
      w_data_reg   <= '0;
      w_lane0_reg  <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      w_full_reg <= w_full_next;
      if (w_take) begin
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      s_axi_wready <= ~w_full_next & ~bvalid_next;
    end
  end

  // Write response: unmapped and read-only words answer with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RVDM_RESP_OKAY;
    end else begin
      s_axi_bvalid <= bvalid_next;
      if (wr_fire) begin
        if (wr_target == RVDM_REG_NONE || wr_target == RVDM_REG_STATUS) begin
          s_axi_bresp <= `RVDM_RESP_SLVERR;
        end else begin
          s_axi_bresp <= `RVDM_RESP_OKAY;
        end
      end
    end
  end

  // Configuration registers: reset loads the factory values, a write
  // with lane 0 strobed replaces them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_map_reg <= otp_pin_map;
      drain_a_reg <= otp_drain_a;
      drain_b_reg <= otp_drain_b & `RVDM_DRAIN_B_MASK;
    end else if (wr_fire && w_lane0_reg) begin
      case (wr_target)
        // Whole byte is four map fields.
        RVDM_REG_MAP: begin
          pin_map_reg <= w_data_reg[7:0];
        end
        // One drain bit per linear regulator 1 to 8.
        RVDM_REG_DRAIN_A: begin
          drain_a_reg <= w_data_reg[7:0];
        end
        // Top two bits are not writable and stay zero.
        RVDM_REG_DRAIN_B: begin
          drain_b_reg <= w_data_reg[7:0] & `RVDM_DRAIN_B_MASK;
        end
        default: begin
          pin_map_reg <= pin_map_reg;
        end
      endcase
    end
  end

  // Read channel: answer one edge after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RVDM_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rvalid  <= rvalid_next;
      s_axi_arready <= ~rvalid_next;
      if (ar_take) begin
        s_axi_rresp <= `RVDM_RESP_OKAY;
        case (rd_target)
          RVDM_REG_MAP: begin
            s_axi_rdata <= {24'h000000, pin_map_reg};
          end
          RVDM_REG_DRAIN_A: begin
            s_axi_rdata <= {24'h000000, drain_a_reg};
          end
          // Unused bits always come back as zero.
          RVDM_REG_DRAIN_B: begin
            s_axi_rdata <= {24'h000000,
                            drain_b_reg & `RVDM_DRAIN_B_MASK};
          end
          // Live view: default bits in 7:4, synchronised pins in 3:0.
          RVDM_REG_STATUS: begin
            s_axi_rdata <= {24'h000000, default_voltage_source_bit,
                            sel_pin_sync};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RVDM_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Default-voltage bits follow the mapped pin every cycle, so a map
  // change takes effect one edge after the write commits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      default_voltage_source_bit <= `RVDM_DEF_BITS_RESET;
    end else begin
      for (int i = 0; i < `RVDM_MAP_REGS; i++) begin
        default_voltage_source_bit[i] <=
          pick_pin(pin_map_reg[2*i +: 2], sel_pin_sync);
      end
    end
  end

  // Voltage code: 0 takes the primary register, 1 the alternate one.
  // This lags the default bit by one edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      linreg_voltage_code <= '0;
    end else begin
      for (int i = 0; i < `RVDM_MAP_REGS; i++) begin
        if (default_voltage_source_bit[i]) begin
          linreg_voltage_code[i] <= linreg_alternate_voltage_reg[i];
        end else begin
          linreg_voltage_code[i] <= linreg_primary_voltage_reg[i];
        end
      end
    end
  end

  // Linear regulator drain: only while the output is disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      linreg_drain_on <= '0;
    end else begin
      linreg_drain_on[7:0] <= drain_a_reg & ~linreg_enabled[7:0];
      linreg_drain_on[9:8] <=
        drain_b_reg[`RVDM_DRAIN_B_LIN_LSB +: 2] &
        ~linreg_enabled[9:8];
    end
  end

  // Converter drain: bits 5:2 for converters 4 to 1.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_drain_on <= '0;
    end else begin
      converter_drain_on <=
        drain_b_reg[`RVDM_DRAIN_B_CNV_LSB +: `RVDM_CONVERTERS] &
        ~converter_enabled;
    end
  end

  // Protection bits carry no meaning here; there is one privilege level.
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1],
                         w_data_reg[31:8], aw_addr_reg[1:0]};

endmodule : rvdm_regs

// ===== tb/regulator_vsel_map_discharge_regs_test.sv
// Self-checking bench of the mapping and drain register block.
`timescale 1ns/1ps
`include "rvdm_params.svh"

module regulator_vsel_map_discharge_regs_test;
  import rvdm_pkg::*;
  logic            aclk = 1'b0, aresetn = 1'b0;
  logic [11:0]     awaddr = 12'h000, araddr = 12'h000;
  logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic            arvalid = 1'b0, rready = 1'b0;
  logic [31:0]     wdata = 32'h0, rdata;
  logic [3:0]      wstrb = 4'hF;  // Byte strobes; lane 0 gates every write.
  logic            awready, wready, bvalid, arready, rvalid;
  logic [1:0]      bresp, rresp;
  logic [3:0]      pin_level = 4'h0, pins, def_bits, cnv_drain;
  logic [9:0]      lin_en = 10'h000, lin_drain;
  logic [3:0]      cnv_en = 4'h0;
  rvdm_code_bank_t prim = 32'h14131211, alt = 32'hA4A3A2A1, code;
  int              num_errors = 0, tests_run = 0;
  // Half period of the 20 MHz clock.
  always #25 aclk = ~aclk;
  rvdm_sel_host pin_u (.aclk(aclk), .level(pin_level),
    .voltage_select_pin(pins));
  rvdm_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .otp_pin_map(8'h50), .otp_drain_a(8'h60), .otp_drain_b(8'hFF),
    .voltage_select_pin(pins), .linreg_primary_voltage_reg(prim),
    .linreg_alternate_voltage_reg(alt), .linreg_enabled(lin_en),
    .converter_enabled(cnv_en), .default_voltage_source_bit(def_bits),
    .linreg_voltage_code(code), .linreg_drain_on(lin_drain),
    .converter_drain_on(cnv_drain));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("Counts: %0d compares, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // A wait that ran out of cycles ends the run as a failure.
  task automatic timed_out;
    num_errors++;
    $display("CHECK FAILED at %0t: bus answer timeout", $time);
    tally_and_finish();
  endtask : timed_out

  // Compares one value with four-state equality.
  task automatic check(input logic [31:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  // Write: both halves offered together, each released once taken.
  // An edge passes first so that back-to-back calls never drive the same
  // signal twice in one time step.
  task automatic bus_wr(input logic [11:0] a, input logic [7:0] d,
                        input logic [1:0] exp_resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check(32'(bresp), 32'(exp_resp), "write response");
        return;
      end
    end
    timed_out();
  endtask : bus_wr

  // Read one word and compare its data and response.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] exp_resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        check(rdata, exp, "read data");
        check(32'(rresp), 32'(exp_resp), "read response");
        return;
      end
    end
    timed_out();
  endtask : rd_chk

  // Factory values must be present right after reset.
  task automatic t_reset_values;
    rd_chk(12'h0B0, 32'h50, `RVDM_RESP_OKAY);
    rd_chk(12'h0B4, 32'h60, `RVDM_RESP_OKAY);
    rd_chk(12'h0B8, 32'h3F, `RVDM_RESP_OKAY);
    $display("reset values done");
  endtask : t_reset_values

  // Two maps that each use every code once, in reversed field order, each pin in turn.
  task automatic t_map;
    logic [7:0] maps [2] = '{8'hE4, 8'h1B};
    logic [3:0] exp;
    logic [7:0] exp_code;
    for (int m = 0; m < 2; m++) begin
      bus_wr(12'h0B0, maps[m], `RVDM_RESP_OKAY);
      for (int p = 0; p < 4; p++) begin
        pin_level <= 4'h1 << p;
        repeat (6) @(posedge aclk);
        for (int i = 0; i < 4; i++) exp[i] = (maps[m][2*i+:2] == p);
        check(32'(def_bits), 32'(exp), "default bits");
        for (int i = 0; i < 4; i++) begin
          exp_code = exp[i] ? alt[i] : prim[i];
          check(32'(code[i]), 32'(exp_code), "code");
        end
      end
    end
    // All pins high: every default bit goes high whatever the map says.
    pin_level <= 4'hF;
    repeat (6) @(posedge aclk);
    check(32'(def_bits), 32'hF, "default bits all high");
    $display("pin mapping done");
  endtask : t_map

  // Drain bits act only while their output is disabled.
  task automatic t_drain;
    bus_wr(12'h0B4, 8'hA5, `RVDM_RESP_OKAY);
    bus_wr(12'h0B8, 8'hC6, `RVDM_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(lin_drain), 32'h2A5, "linreg drain");
    check(32'(cnv_drain), 32'h1, "converter drain");
    rd_chk(12'h0B8, 32'h06, `RVDM_RESP_OKAY);
    lin_en <= 10'h0F0;
    cnv_en <= 4'h1;
    repeat (3) @(posedge aclk);
    check(32'(lin_drain), 32'h205, "linreg drain enabled");
    check(32'(cnv_drain), 32'h0, "converter drain enabled");
    rd_chk(12'h0FC, 32'h0, `RVDM_RESP_SLVERR);
    $display("drain done");
  endtask : t_drain

  // A write with lane 0 unstrobed leaves the register alone; the status
  // word refuses writes and shows the pins, still all high from t_map.
  task automatic t_strobe_status;
    wstrb <= 4'h0;
    bus_wr(12'h0B4, 8'h00, `RVDM_RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(12'h0B4, 32'hA5, `RVDM_RESP_OKAY);
    bus_wr(12'h100, 8'h00, `RVDM_RESP_SLVERR);
    rd_chk(12'h100, 32'hFF, `RVDM_RESP_OKAY);
    $display("strobe and status done");
  endtask : t_strobe_status

  // Reset for twenty cycles, then run every scenario.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_map();
    t_drain();
    t_strobe_status();
    tally_and_finish();
  end
endmodule : regulator_vsel_map_discharge_regs_test

// ===== tb/rvdm_regs_checker.sv
// Port-level assertions for the mapping and drain register block.
`timescale 1ns/1ps
`include "rvdm_params.svh"

module rvdm_regs_checker (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic [`RVDM_ADDR_W-1:0]   s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic [3:0]                voltage_select_pin,
  input wire rvdm_pkg::rvdm_code_bank_t linreg_primary_voltage_reg,
  input wire rvdm_pkg::rvdm_code_bank_t linreg_alternate_voltage_reg,
  input wire logic [9:0]                linreg_enabled,
  input wire logic [3:0]                converter_enabled,
  input wire logic [3:0]                default_voltage_source_bit,
  input wire rvdm_pkg::rvdm_code_bank_t linreg_voltage_code,
  input wire logic [9:0]                linreg_drain_on,
  input wire logic [3:0]                converter_drain_on
);
  import rvdm_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [`RVDM_ADDR_W-1:0] rd_addr_reg; // Address of the read in flight.
  // Remember the read address so read data can be judged per register.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
  end
  AST_LIN_DRAIN: assert property (
    (linreg_drain_on & $past(linreg_enabled)) == 10'h000)
    else $error("linreg drain on while enabled");
  AST_CNV_DRAIN: assert property (
    (converter_drain_on & $past(converter_enabled)) == 4'h0)
    else $error("converter drain on while enabled");
  AST_CODE_ONE: assert property ($past(aresetn) |->
    linreg_voltage_code[0] == ($past(default_voltage_source_bit[0]) ?
    $past(linreg_alternate_voltage_reg[0]) :
    $past(linreg_primary_voltage_reg[0])))
    else $error("linreg one code wrong source");
  AST_CODE_FOUR: assert property ($past(aresetn) |->
    linreg_voltage_code[3] == ($past(default_voltage_source_bit[3]) ?
    $past(linreg_alternate_voltage_reg[3]) :
    $past(linreg_primary_voltage_reg[3])))
    else $error("linreg four code wrong source");
  AST_PINS_HIGH: assert property (
    (voltage_select_pin == 4'hF)[*5] |-> default_voltage_source_bit == 4'hF)
    else $error("default bits not high");
  AST_PINS_LOW: assert property (
    (voltage_select_pin == 4'h0)[*5] |-> default_voltage_source_bit == 4'h0)
    else $error("default bits not low");
  AST_RD_UNUSED: assert property (
    s_axi_rvalid && rd_addr_reg == 12'h0B8 |-> s_axi_rdata[7:6] == 2'b00)
    else $error("drain b unused bits read nonzero");
  AST_RD_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits nonzero");
  cover property (s_axi_rvalid && rd_addr_reg == 12'h0B8);
  cover property ($rose(default_voltage_source_bit[0]));
  cover property (converter_drain_on != 4'h0);
endmodule : rvdm_regs_checker

bind rvdm_regs rvdm_regs_checker chk_u (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .voltage_select_pin, .linreg_primary_voltage_reg,
  .linreg_alternate_voltage_reg, .linreg_enabled, .converter_enabled,
  .default_voltage_source_bit, .linreg_voltage_code, .linreg_drain_on,
  .converter_drain_on);

// ===== tb/rvdm_sel_host.sv
// Host-side model that drives the four voltage select pins.
`timescale 1ns/1ps

module rvdm_sel_host (
  input  wire logic       aclk,
  input  wire logic [3:0] level,
  output logic      [3:0] voltage_select_pin
);
  // Pins move only just after an edge, as a host port register would.
  always_ff @(posedge aclk) begin
    voltage_select_pin <= level;
  end
endmodule : rvdm_sel_host
